// ---- rtl/srcp_pkg.sv ----
package srcp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS   = 32'h00000014;
  localparam int TICK_NS  = 32'h000F4240;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [4:0] LPF_STEPS = 5'h19;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_SEL = 8'h00;
  localparam logic [7:0] ADDR_SRC_SEL  = 8'h04;
  localparam logic [7:0] ADDR_SETPOINT = 8'h08;
  localparam logic [7:0] ADDR_CH1_OFS  = 8'h0C;
  localparam logic [7:0] ADDR_CH1_FLT  = 8'h10;
  localparam logic [7:0] ADDR_CH1_DB   = 8'h14;
  localparam logic [7:0] ADDR_CH1_DRF  = 8'h18;
  localparam logic [7:0] ADDR_CH2_OFS  = 8'h1C;
  localparam logic [7:0] ADDR_CH2_FLT  = 8'h20;
  localparam logic [7:0] ADDR_CH2_DB   = 8'h24;
  localparam logic [7:0] ADDR_CH2_DRF  = 8'h28;
  localparam logic [7:0] ADDR_FS_SPEED = 8'h2C;
  localparam logic [7:0] ADDR_FS_TORQ  = 8'h30;
  localparam logic [7:0] ADDR_CH1_MON  = 8'h34;
  localparam logic [7:0] ADDR_CH2_MON  = 8'h38;
  localparam logic [7:0] ADDR_CAL      = 8'h3C;
  localparam logic [7:0] ADDR_STATUS   = 8'h40;

  // ------------------------------------------------------------
  // Values after reset and limits
  // ------------------------------------------------------------
  localparam logic [3:0]  MODE_RST   = 4'h1;
  localparam logic [3:0]  MODE_SPEED = 4'h2;
  localparam int          MODE_MIN   = 32'h00000001;
  localparam int          MODE_MAX   = 32'h0000000A;
  localparam logic [15:0] SETPT_RST  = 16'h0064;
  localparam int          SETPT_MAX  = 32'h00000BB8;
  localparam int          OFS_MAX    = 32'h00001388;
  localparam int          DRIFT_MAX  = 32'h000001F4;
  localparam logic [15:0] FLT_RST    = 16'h00C8;
  localparam logic [15:0] DB_RST     = 16'h0014;
  localparam int          DB_MAX     = 32'h000003E8;
  localparam logic [15:0] FSS_RST    = 16'h0BB8;
  localparam int          FSS_MIN    = 32'h000003E8;
  localparam int          FSS_MAX    = 32'h00001194;
  localparam logic [15:0] FST_RST    = 16'h03E8;
  localparam int          FST_MAX    = 32'h00000BB8;
  localparam logic [15:0] FULL_MV    = 16'h2710;

endpackage : srcp_pkg

// ---- rtl/srcp_filt_if.sv ----
`timescale 1ns/1ns
// Carries one channel's sample, time constant and tick into its filter
interface srcp_filt_if;
  logic signed [15:0] x;
  logic        [15:0] tau;
  logic               tick;
  logic signed [15:0] y;
  modport filt (input x, input tau, input tick, output y);
  modport user (output x, output tau, output tick, input y);
endinterface : srcp_filt_if

// ---- rtl/srcp_cond.sv ----
`timescale 1ns/1ns
module srcp_cond (
  // Clock and reset
  input  logic              pclk,
  input  logic              presetn,
  // Sample in
  input  logic signed [15:0] raw,
  input  logic              strobe,
  // Settings
  input  logic signed [15:0] drift,
  input  logic signed [15:0] offset,
  input  logic        [15:0] db,
  // Conditioned sample
  output logic signed [15:0] v
);

  typedef struct packed {
    logic signed [15:0] v;
  } srcp_cond_s;

  srcp_cond_s         st;
  srcp_cond_s         next_st;
  logic signed [17:0] c;
  logic signed [17:0] lim;

  always_comb begin
    next_st = st;
    c = 18'(raw) - 18'(drift) - 18'(offset);
    lim = $signed({2'b00, db});
    if (c > 18'sh07FFF) begin
      c = 18'sh07FFF;
    end else if (c < 18'sh38000) begin
      c = 18'sh38000;
    end
    if (c <= lim && c >= -lim) begin
      c = 18'sh00000;
    end
    if (strobe) begin
      next_st.v = c[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign v = st.v;

  a_dead_zero : assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe && (c == 18'sh00000) |=> v == 16'sh0000
  ) else $error("Sample inside dead zone not forced to zero");

endmodule : srcp_cond

// ---- rtl/srcp_lpf.sv ----
`timescale 1ns/1ns
module srcp_lpf (
  // Clock and reset
  input  logic      pclk,
  input  logic      presetn,
  // Channel
  srcp_filt_if.filt f
);

  // Eight fraction bits keep the filter creeping toward the input
  // even when the step is smaller than one millivolt per tick.
  typedef struct packed {
    logic signed [23:0] acc;
    logic        [24:0] num;
    logic        [16:0] rem;
    logic        [4:0]  cnt;
    logic               neg;
    logic               busy;
    logic signed [15:0] y;
  } srcp_lpf_s;

  srcp_lpf_s          st;
  srcp_lpf_s          next_st;
  logic signed [24:0] d;
  logic        [17:0] r2;
  logic        [16:0] dv;

  // Per tick: acc += (x - acc) / (tau + 1), a first-order lag
  always_comb begin
    next_st = st;
    dv = {1'b0, f.tau} + 17'h00001;
    d = 25'($signed({f.x, 8'h00})) - 25'(st.acc);
    r2 = {st.rem, st.num[24]};
    if (st.busy) begin
      next_st.num = {st.num[23:0], 1'b0};
      if (r2 >= {1'b0, dv}) begin
        r2 = r2 - {1'b0, dv};
        next_st.num[0] = 1'b1;
      end
      next_st.rem = r2[16:0];
      next_st.cnt = st.cnt - 5'h01;
      if (st.cnt == 5'h01) begin
        next_st.busy = 1'b0;
        if (st.neg) begin
          next_st.acc = st.acc - $signed(next_st.num[23:0]);
        end else begin
          next_st.acc = st.acc + $signed(next_st.num[23:0]);
        end
        next_st.y = next_st.acc[23:8];
      end
    end else if (f.tick) begin
      next_st.busy = 1'b1;
      next_st.neg = d[24];
      next_st.num = d[24] ? -d : d;
      next_st.rem = 17'h00000;
      next_st.cnt = srcp_pkg::LPF_STEPS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.y = st.y;

  a_div_length : assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.busy) |-> ##25 !st.busy
  ) else $error("Filter update did not finish in 25 cycles");

  a_out_hold : assert property (
    @(posedge pclk) disable iff (!presetn)
    st.busy && st.cnt != 5'h01 |=> $stable(st.y)
  ) else $error("Filter output moved during an update");

endmodule : srcp_lpf

// ---- rtl/srcp_speed_ref.sv ----
`timescale 1ns/1ns
module srcp_speed_ref #(
  parameter int TICK_CYCLES = srcp_pkg::TICK_CYC
) (
  // Clock and reset
  input  logic               pclk,
  input  logic               presetn,
  // APB slave
  input  logic        [7:0]  paddr,
  input  logic               psel,
  input  logic               penable,
  input  logic               pwrite,
  input  logic        [31:0] pwdata,
  output logic        [31:0] prdata,
  output logic               pready,
  output logic               pslverr,
  // Converted analog samples, millivolts
  input  logic signed [15:0] analog_in_one,
  input  logic signed [15:0] analog_in_two,
  input  logic               sample_valid,
  // Drive state
  input  logic               motor_running,
  // References
  output logic               speed_mode,
  output logic signed [15:0] speed_ref,
  output logic signed [15:0] torque_ref
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic        [3:0]  operating_mode_select;
    logic               speed_source_select;
    logic signed [15:0] internal_speed_setpoint;
    logic signed [15:0] ch1_offset;
    logic        [15:0] ch1_filter_time;
    logic        [15:0] ch1_deadband;
    logic signed [15:0] ch1_drift_cal;
    logic signed [15:0] ch2_offset;
    logic        [15:0] ch2_filter_time;
    logic        [15:0] ch2_deadband;
    logic signed [15:0] ch2_drift_cal;
    logic        [15:0] full_scale_speed;
    logic        [15:0] full_scale_torque;
    logic signed [15:0] ch1_voltage_monitor;
    logic signed [15:0] ch2_voltage_monitor;
    logic               speed_mode;
    logic signed [15:0] speed_ref;
    logic signed [15:0] torque_ref;
    logic        [31:0] tick_cnt;
    logic               tick;
    logic        [31:0] prdata;
    logic               pready;
    logic               pslverr;
  } srcp_regs_s;

  localparam srcp_regs_s ST_RST = '{
    operating_mode_select:   srcp_pkg::MODE_RST,
    internal_speed_setpoint: srcp_pkg::SETPT_RST,
    ch1_filter_time:         srcp_pkg::FLT_RST,
    ch1_deadband:            srcp_pkg::DB_RST,
    ch2_filter_time:         srcp_pkg::FLT_RST,
    ch2_deadband:            srcp_pkg::DB_RST,
    full_scale_speed:        srcp_pkg::FSS_RST,
    full_scale_torque:       srcp_pkg::FST_RST,
    default:                 '0
  };

  srcp_regs_s         st;
  srcp_regs_s         next_st;
  logic signed [31:0] wds;
  logic signed [31:0] wdu;
  logic               wr;
  logic signed [15:0] v1;
  logic signed [15:0] v2;
  logic signed [15:0] y1;
  logic signed [15:0] y2;

  srcp_filt_if f1 ();
  srcp_filt_if f2 ();

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic signed [15:0] sat(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    if (v < lo) begin
      sat = lo[15:0];
    end else if (v > hi) begin
      sat = hi[15:0];
    end else begin
      sat = v[15:0];
    end
  endfunction : sat

  // Ten volts at the conditioned input gives the full-scale value
  function automatic logic signed [15:0] scale(
    input logic signed [15:0] mv,
    input logic        [15:0] fs
  );
    logic signed [31:0] p;
    p = 32'(mv) * $signed({16'h0000, fs});
    p = p / $signed({16'h0000, srcp_pkg::FULL_MV});
    scale = p[15:0];
  endfunction : scale

  function automatic logic [31:0] rd(
    input logic       [7:0] a,
    input srcp_regs_s       s,
    input logic             run
  );
    rd = 32'h00000000;
    case (a)
      srcp_pkg::ADDR_MODE_SEL: rd[3:0]  = s.operating_mode_select;
      srcp_pkg::ADDR_SRC_SEL:  rd[0]    = s.speed_source_select;
      srcp_pkg::ADDR_SETPOINT: rd[15:0] = s.internal_speed_setpoint;
      srcp_pkg::ADDR_CH1_OFS:  rd[15:0] = s.ch1_offset;
      srcp_pkg::ADDR_CH1_FLT:  rd[15:0] = s.ch1_filter_time;
      srcp_pkg::ADDR_CH1_DB:   rd[15:0] = s.ch1_deadband;
      srcp_pkg::ADDR_CH1_DRF:  rd[15:0] = s.ch1_drift_cal;
      srcp_pkg::ADDR_CH2_OFS:  rd[15:0] = s.ch2_offset;
      srcp_pkg::ADDR_CH2_FLT:  rd[15:0] = s.ch2_filter_time;
      srcp_pkg::ADDR_CH2_DB:   rd[15:0] = s.ch2_deadband;
      srcp_pkg::ADDR_CH2_DRF:  rd[15:0] = s.ch2_drift_cal;
      srcp_pkg::ADDR_FS_SPEED: rd[15:0] = s.full_scale_speed;
      srcp_pkg::ADDR_FS_TORQ:  rd[15:0] = s.full_scale_torque;
      srcp_pkg::ADDR_CH1_MON:  rd[15:0] = s.ch1_voltage_monitor;
      srcp_pkg::ADDR_CH2_MON:  rd[15:0] = s.ch2_voltage_monitor;
      srcp_pkg::ADDR_STATUS:   rd = {s.speed_ref, 14'h0000, run, s.speed_mode};
      default:                 rd = 32'h00000000;
    endcase
  endfunction : rd

  // ------------------------------------------------------------
  // Channel pipelines
  // ------------------------------------------------------------
  srcp_cond u_cond1 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (analog_in_one),
    .strobe  (sample_valid),
    .drift   (st.ch1_drift_cal),
    .offset  (st.ch1_offset),
    .db      (st.ch1_deadband),
    .v       (v1)
  );

  srcp_cond u_cond2 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (analog_in_two),
    .strobe  (sample_valid),
    .drift   (st.ch2_drift_cal),
    .offset  (st.ch2_offset),
    .db      (st.ch2_deadband),
    .v       (v2)
  );

  // Filters see the dead-zoned value, never the raw sample
  assign f1.x    = v1;
  assign f1.tau  = st.ch1_filter_time;
  assign f1.tick = st.tick;
  assign f2.x    = v2;
  assign f2.tau  = st.ch2_filter_time;
  assign f2.tick = st.tick;
  assign y1      = f1.y;
  assign y2      = f2.y;

  srcp_lpf u_lpf1 (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (f1.filt)
  );

  srcp_lpf u_lpf2 (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (f2.filt)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  assign wds = 32'($signed(pwdata[15:0]));
  assign wdu = 32'({16'h0000, pwdata[15:0]});
  assign wr  = psel && penable && st.pready && pwrite && !st.pslverr;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.tick_cnt = st.tick_cnt + 32'h00000001;
    if (st.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = 32'h00000000;
      next_st.tick = 1'b1;
    end

    // Zero-wait APB: read data is fetched in the setup cycle
    next_st.pready = 1'b0;
    if (psel && !penable) begin
      next_st.pready = 1'b1;
      next_st.prdata = rd(paddr, st, motor_running);
      next_st.pslverr = !(paddr inside {[srcp_pkg::ADDR_MODE_SEL:srcp_pkg::ADDR_STATUS]})
                        || (paddr[1:0] != 2'b00);
    end

    if (wr) begin
      case (paddr)
        srcp_pkg::ADDR_MODE_SEL: begin
          if (!motor_running) begin
            next_st.operating_mode_select = 4'(sat(wdu, srcp_pkg::MODE_MIN, srcp_pkg::MODE_MAX));
          end
        end
        srcp_pkg::ADDR_SRC_SEL: begin
          if (!motor_running) begin
            next_st.speed_source_select = pwdata[0];
          end
        end
        srcp_pkg::ADDR_SETPOINT: begin
          next_st.internal_speed_setpoint = sat(wds, -srcp_pkg::SETPT_MAX, srcp_pkg::SETPT_MAX);
        end
        srcp_pkg::ADDR_CH1_OFS: begin
          next_st.ch1_offset = sat(wds, -srcp_pkg::OFS_MAX, srcp_pkg::OFS_MAX);
        end
        srcp_pkg::ADDR_CH1_FLT: next_st.ch1_filter_time = pwdata[15:0];
        srcp_pkg::ADDR_CH1_DB: begin
          next_st.ch1_deadband = sat(wdu, 32'h00000000, srcp_pkg::DB_MAX);
        end
        srcp_pkg::ADDR_CH1_DRF: begin
          next_st.ch1_drift_cal = sat(wds, -srcp_pkg::DRIFT_MAX, srcp_pkg::DRIFT_MAX);
        end
        srcp_pkg::ADDR_CH2_OFS: begin
          next_st.ch2_offset = sat(wds, -srcp_pkg::OFS_MAX, srcp_pkg::OFS_MAX);
        end
        srcp_pkg::ADDR_CH2_FLT: next_st.ch2_filter_time = pwdata[15:0];
        srcp_pkg::ADDR_CH2_DB: begin
          next_st.ch2_deadband = sat(wdu, 32'h00000000, srcp_pkg::DB_MAX);
        end
        srcp_pkg::ADDR_CH2_DRF: begin
          next_st.ch2_drift_cal = sat(wds, -srcp_pkg::DRIFT_MAX, srcp_pkg::DRIFT_MAX);
        end
        srcp_pkg::ADDR_FS_SPEED: begin
          if (!motor_running) begin
            next_st.full_scale_speed = sat(wdu, srcp_pkg::FSS_MIN, srcp_pkg::FSS_MAX);
          end
        end
        srcp_pkg::ADDR_FS_TORQ: begin
          if (!motor_running) begin
            next_st.full_scale_torque = sat(wdu, 32'h00000000, srcp_pkg::FST_MAX);
          end
        end
        srcp_pkg::ADDR_CAL: begin
          // Input must be grounded; the present sample is taken as drift
          if (pwdata[0]) begin
            next_st.ch1_drift_cal = sat(32'(analog_in_one), -srcp_pkg::DRIFT_MAX, srcp_pkg::DRIFT_MAX);
          end
          if (pwdata[1]) begin
            next_st.ch2_drift_cal = sat(32'(analog_in_two), -srcp_pkg::DRIFT_MAX, srcp_pkg::DRIFT_MAX);
          end
        end
        default: next_st.pslverr = st.pslverr;
      endcase
    end

    // Reference selection and scaling
    next_st.ch1_voltage_monitor = y1;
    next_st.ch2_voltage_monitor = y2;
    next_st.speed_mode = (st.operating_mode_select == srcp_pkg::MODE_SPEED);
    next_st.speed_ref = 16'sh0000;
    if (st.operating_mode_select == srcp_pkg::MODE_SPEED) begin
      if (st.speed_source_select) begin
        next_st.speed_ref = scale(y1, st.full_scale_speed);
      end else begin
        next_st.speed_ref = st.internal_speed_setpoint;
      end
    end
    next_st.torque_ref = scale(y2, st.full_scale_torque);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign speed_mode = st.speed_mode;
  assign speed_ref  = st.speed_ref;
  assign torque_ref = st.torque_ref;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_mode_speed : assert property (
    ##1 st.speed_mode == ($past(st.operating_mode_select) == srcp_pkg::MODE_SPEED)
  ) else $error("Speed mode flag does not follow mode select");
  a_ref_off : assert property (
    !st.speed_mode && (st.operating_mode_select != srcp_pkg::MODE_SPEED) |=> speed_ref == 16'sh0000
  ) else $error("Speed reference not zero outside speed mode");
  a_src_int : assert property (
    (st.operating_mode_select == srcp_pkg::MODE_SPEED) && !st.speed_source_select
    |=> speed_ref == $past(st.internal_speed_setpoint)
  ) else $error("Internal setpoint not routed to speed reference");
  a_src_ana : assert property (
    (st.operating_mode_select == srcp_pkg::MODE_SPEED) && st.speed_source_select
    |=> speed_ref == scale($past(y1), $past(st.full_scale_speed))
  ) else $error("Analog speed reference wrongly scaled");
  a_setpt_lim : assert property (
    st.internal_speed_setpoint <= 16'sh0BB8 && st.internal_speed_setpoint >= -16'sh0BB8
  ) else $error("Internal setpoint beyond 3000 rpm");
  a_ofs_lim : assert property (
    st.ch1_offset <= 16'sh1388 && st.ch1_offset >= -16'sh1388
  ) else $error("Channel one offset beyond 5000 mV");
  a_ofs2_lim : assert property (
    st.ch2_offset <= 16'sh1388 && st.ch2_offset >= -16'sh1388
  ) else $error("Channel two offset beyond 5000 mV");
  a_drift_cal : assert property (
    wr && (paddr == srcp_pkg::ADDR_CAL) && pwdata[0] && analog_in_one < 16'sh01F4
    && analog_in_one > -16'sh01F4 |=> st.ch1_drift_cal == $past(analog_in_one)
  ) else $error("Drift calibration did not capture channel one");
  a_db_lim : assert property (
    st.ch1_deadband <= 16'h03E8 && st.ch2_deadband <= 16'h03E8
  ) else $error("Dead zone beyond 1000 mV");
  a_fs_stop : assert property (
    motor_running |=> $stable(st.full_scale_speed) && $stable(st.operating_mode_select)
  ) else $error("Stop-only setting changed while running");
  a_fss_range : assert property (
    st.full_scale_speed >= 16'h03E8 && st.full_scale_speed <= 16'h1194
  ) else $error("Full-scale speed out of range");
  a_trq_scale : assert property (
    ##1 torque_ref == scale($past(y2), $past(st.full_scale_torque))
  ) else $error("Torque reference wrongly scaled");
  a_mon_track : assert property (
    ##1 st.ch1_voltage_monitor == $past(y1) && st.ch2_voltage_monitor == $past(y2)
  ) else $error("Voltage monitor does not follow filter output");
  a_apb_ready : assert property (
    psel && !penable |=> pready ##1 !pready
  ) else $error("APB answer not one cycle after setup");

endmodule : srcp_speed_ref

// ---- tb/srcp_host_model.sv ----
`timescale 1ns/1ns
// Host side: holds one level per channel and strobes a conversion every 8 cycles
module srcp_host_model (
  // Clock and reset
  input  logic               pclk,
  input  logic               presetn,
  // Levels asked of the host, mV
  input  logic signed [15:0] lvl_one,
  input  logic signed [15:0] lvl_two,
  // Converted samples
  output logic signed [15:0] analog_in_one,
  output logic signed [15:0] analog_in_two,
  output logic               sample_valid
);
  logic [2:0] div;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div           <= 3'h0;
      sample_valid  <= 1'b0;
      analog_in_one <= 16'sh0;
      analog_in_two <= 16'sh0;
    end else begin
      div          <= div + 3'h1;
      sample_valid <= (div == 3'h7);
      // New level shows only with a strobe, like a converter
      if (div == 3'h7) begin
        analog_in_one <= lvl_one;
        analog_in_two <= lvl_two;
      end
    end
  end
endmodule : srcp_host_model

// ---- tb/tb_srcp_speed_ref.sv ----
`timescale 1ns/1ns
module tb_srcp_speed_ref;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, motor_running, speed_mode, er;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic signed [15:0] analog_in_one, analog_in_two, speed_ref, torque_ref, lvl1, lvl2;
  int n_fail, check_count, cyc;
  logic [7:0]  ra[6] = '{8'h00, 8'h08, 8'h10, 8'h14, 8'h2C, 8'h30};
  logic [15:0] rv[6] = '{16'h0001, 16'h0064, 16'h00C8, 16'h0014, 16'h0BB8, 16'h03E8};

  srcp_speed_ref #(.TICK_CYCLES(32)) srcp_speed_ref_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
    .sample_valid(sample_valid), .motor_running(motor_running), .speed_mode(speed_mode),
    .speed_ref(speed_ref), .torque_ref(torque_ref));
  srcp_host_model srcp_host_model_i (.pclk(pclk), .presetn(presetn), .lvl_one(lvl1), .lvl_two(lvl2),
    .analog_in_one(analog_in_one), .analog_in_two(analog_in_two), .sample_valid(sample_valid));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Expected conditioned voltage with the default 20 mV dead zone
  function automatic int cond(int raw, int ofs);
    int v;
    v = raw - ofs;
    if (v <= 20 && v >= -20) v = 0;
    return v;
  endfunction : cond

  task stop_test();
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // Sequence should end near 1000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    int r1, r2, v1, v2;
    {psel, penable, pwrite, motor_running, presetn} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl1 = 16'sh0;
    lvl2 = 16'sh0;
    void'($urandom(32'hD12E8BBB));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(ra[i], 1'b0, 32'h0);
      chk(rd[15:0], rv[i]);
    end
    chk(speed_ref, 16'h0000);
    lvl1 <= 16'sh0064;
    lvl2 <= -16'sh0064;
    repeat (20) @(posedge pclk);
    apb(srcp_pkg::ADDR_CAL, 1'b1, 32'h3);
    apb(srcp_pkg::ADDR_CH2_DRF, 1'b0, 32'h0);
    chk(rd[15:0], 16'hFF9C);
    lvl1 <= 16'sh02BC;
    repeat (20) @(posedge pclk);
    apb(srcp_pkg::ADDR_CAL, 1'b1, 32'h1);
    apb(srcp_pkg::ADDR_CH1_DRF, 1'b0, 32'h0);
    chk(rd[15:0], 16'h01F4);
    apb(srcp_pkg::ADDR_CH1_FLT, 1'b1, 32'h0);
    apb(srcp_pkg::ADDR_CH2_FLT, 1'b1, 32'h0);
    apb(srcp_pkg::ADDR_CH1_OFS, 1'b1, 32'h3E8);
    apb(srcp_pkg::ADDR_CH2_OFS, 1'b1, 32'hFFFFFF9C);
    apb(srcp_pkg::ADDR_MODE_SEL, 1'b1, 32'h3);
    repeat (3) @(posedge pclk);
    chk({15'h0, speed_mode}, 16'h0000);
    apb(srcp_pkg::ADDR_MODE_SEL, 1'b1, 32'h2);
    apb(srcp_pkg::ADDR_SETPOINT, 1'b1, 32'hFFFFF254);
    repeat (3) @(posedge pclk);
    chk({15'h0, speed_mode}, 16'h0001);
    chk(speed_ref, 16'hF448);
    apb(srcp_pkg::ADDR_SRC_SEL, 1'b1, 32'h1);
    for (int i = 0; i < 8; i++) begin
      r1 = (i == 0) ? 1520 : (i == 1) ? 1521 : int'($urandom_range(9000, 0)) - 4000;
      r2 = int'($urandom_range(6000, 0)) - 3000;
      lvl1 <= 16'(r1);
      lvl2 <= 16'(r2);
      repeat (100) @(posedge pclk);
      v1 = cond(r1, 1500);
      // Channel two carries -100 mV drift and -100 mV offset
      v2 = cond(r2, -200);
      chk(speed_ref, 16'(v1 * 3000 / 10000));
      chk(torque_ref, 16'(v2 * 1000 / 10000));
      apb(srcp_pkg::ADDR_CH1_MON, 1'b0, 32'h0);
      chk(rd[15:0], 16'(v1));
      apb(srcp_pkg::ADDR_CH2_MON, 1'b0, 32'h0);
      chk(rd[15:0], 16'(v2));
    end
    motor_running <= 1'b1;
    apb(srcp_pkg::ADDR_FS_SPEED, 1'b1, 32'hFA0);
    apb(srcp_pkg::ADDR_MODE_SEL, 1'b1, 32'h1);
    apb(srcp_pkg::ADDR_FS_SPEED, 1'b0, 32'h0);
    chk(rd[15:0], 16'h0BB8);
    chk({15'h0, speed_mode}, 16'h0001);
    motor_running <= 1'b0;
    apb(srcp_pkg::ADDR_FS_SPEED, 1'b1, 32'h1F4);
    apb(srcp_pkg::ADDR_FS_SPEED, 1'b0, 32'h0);
    chk(rd[15:0], 16'h03E8);
    apb(8'h44, 1'b0, 32'h0);
    chk({15'h0, er}, 16'h0001);
    chk(rd[15:0], 16'h0000);
    apb(srcp_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[15:0], 16'h0001);
    chk(rd[31:16], 16'(v1 * 1000 / 10000));
    stop_test();
  end
endmodule : tb_srcp_speed_ref
